/* lsd_pkg.sv */
package lsd_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ           = 250000; // 250 MHz system clock
  localparam int TICK_MS           = 1;      // divider enable period
  localparam int TICK_CYCLES       = CLK_KHZ * TICK_MS;
  localparam int HOLD_TIME_MS      = 3000;   // hold to enter review
  localparam int HOLD_TICKS        = HOLD_TIME_MS / TICK_MS;
  localparam int DEBOUNCE_TIME_MS  = 10;
  localparam int DEBOUNCE_TICKS    = DEBOUNCE_TIME_MS / TICK_MS;
  localparam int REVIEW_TIMEOUT_MS = 10000;
  localparam int REVIEW_TICKS      = REVIEW_TIMEOUT_MS / TICK_MS;
  localparam int LEARN_SETTLE_MS   = 100;    // wait before the drop is read
  localparam int SETTLE_TICKS      = LEARN_SETTLE_MS / TICK_MS;

  // ----------------------------------------------------------------------
  // loads, relays, limits and display
  // ----------------------------------------------------------------------
  localparam int        NUM_LOADS       = 4;
  localparam int        CUR_W           = 8;
  localparam int        RELAY_COMP      = 2;  // third relay, compressor
  localparam int        RELAY_FAN       = 3;  // fourth relay, fan
  localparam logic [5:0] LIMIT_HIGH_A   = 6'h1E; // 30 A
  localparam logic [5:0] LIMIT_LOW_A    = 6'h14; // 20 A
  localparam logic [7:0] METER_MAX      = 8'h63; // 99, two digits
  localparam int        SW_ORDER_LSB    = 0;  // positions one to three
  localparam int        SW_STANDALONE   = 4;  // position five
  localparam logic [5:0] SW_FACTORY     = 6'h3F;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_METER     = 8'h08;
  localparam logic [7:0]  REG_LEARNED   = 8'h0C;
  localparam int          CTRL_SHED_EN  = 0;
  localparam int          CTRL_EXIT_REV = 1;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    LSD_SVC_OFF    = 2'b00,
    LSD_SVC_SHORE  = 2'b01,
    LSD_SVC_GEN    = 2'b10,
    LSD_SVC_FIFTY  = 2'b11
  } lsd_service_e;

endpackage : lsd_pkg

/* lsd_button.sv */
`timescale 1ns/10ps
module lsd_button
  import lsd_pkg::*;
#(
  parameter int unsigned DEBOUNCE = DEBOUNCE_TICKS,
  parameter int unsigned HOLD     = HOLD_TICKS
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ms_tick,
  input  wire logic btn_raw,
  output logic      press_pulse,
  output logic      hold_pulse
);

  logic        stable;
  logic [7:0]  db_cnt;
  logic [15:0] hold_cnt;
  logic        held;

  // ----------------------------------------------------------------------
  // debounce: the level must stay changed for the whole window
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stable <= 1'b0;
      db_cnt <= 8'h00;
    end
    else if (btn_raw == stable)
      db_cnt <= 8'h00;
    else if (ms_tick)
    begin
      if (db_cnt >= 8'(DEBOUNCE - 1))
      begin
        stable <= btn_raw;
        db_cnt <= 8'h00;
      end
      else
        db_cnt <= db_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // hold timing and press classification
  // ----------------------------------------------------------------------
  // a press acts on release so a long hold never also toggles the limit
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      hold_cnt    <= 16'h0000;
      held        <= 1'b0;
      press_pulse <= 1'b0;
      hold_pulse  <= 1'b0;
    end
    else
    begin
      press_pulse <= 1'b0;
      hold_pulse  <= 1'b0;
      if (!stable)
      begin
        if (hold_cnt != 16'h0000 || held)
          press_pulse <= !held;
        hold_cnt <= 16'h0000;
        held     <= 1'b0;
      end
      else if (ms_tick && !held)
      begin
        if (hold_cnt >= 16'(HOLD - 1))
        begin
          hold_pulse <= 1'b1;
          held       <= 1'b1;
        end
        else
          hold_cnt <= hold_cnt + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_press_after_release: assert property (
    press_pulse |-> !stable && !$past(held))
    else $error("press reported while button still down or held");

  a_hold_once: assert property (
    hold_pulse |=> !hold_pulse && held)
    else $error("hold reported twice in a row");

endmodule : lsd_button

/* lsd_ctrl.sv */
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// What this block does
// - load leds lit while load powered
// - meter shows live total current
// - select chooses 30 A or 20 A limit
// - line power applied starts in 30 A
// - momentary press on shore power toggles 30 A and 20 A
// - line plus generator run lights generator led
// - split phase supply lights fifty amp led
// - line without generator lights thirty amp led outside reduced mode
// - twenty amp led only in reduced mode
// - three second hold enters load review
// - review press steps to next load
// - never shed load reviews as zero
// - review idle returns to live display
// - switches one to three set order
// - switch four has no effect
// - switch five on means stand alone
// - all on is standard, stand alone
// - compressor shed energises third relay
// - fan shed energises fourth relay
// - learned current is drop at shed
// - fifty amp: no shedding, blank, leds on
// - reduced mode manages with 20 A limit
module lsd_ctrl
  import lsd_pkg::*;
#(
  parameter int unsigned TICK_DIV   = TICK_CYCLES,
  parameter int unsigned REVIEW_TO  = REVIEW_TICKS,
  parameter int unsigned HOLD       = HOLD_TICKS,
  parameter int unsigned DEBOUNCE   = DEBOUNCE_TICKS,
  parameter int unsigned SETTLE     = SETTLE_TICKS
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 line_one_input,
  input  wire logic                 line_two_input,
  input  wire logic                 split_phase_detect,
  input  wire logic                 gen_run,
  input  wire logic [lsd_pkg::CUR_W-1:0] total_current,
  input  wire logic [lsd_pkg::NUM_LOADS-1:0] shed_req,
  input  wire logic                 select_btn,
  input  wire logic [5:0]           cfg_sw,
  output logic [lsd_pkg::NUM_LOADS-1:0] relay_out,
  output logic [lsd_pkg::NUM_LOADS-1:0] load_led,
  output logic                      led_gen,
  output logic                      led_fifty,
  output logic                      led_thirty,
  output logic                      led_twenty,
  output logic [3:0]                meter_tens,
  output logic [3:0]                meter_ones,
  output logic                      meter_blank,
  output logic [5:0]                limit_amps,
  output logic [2:0]                shed_order,
  output logic                      stand_alone
);

  logic [17:0]       div_cnt;
  logic              ms_tick;
  logic              press_pulse;
  logic              hold_pulse;
  logic              powered;
  logic              power_q;
  logic              limit_low;
  logic              review;
  logic [1:0]        rev_idx;
  logic [15:0]       rev_cnt;
  logic [31:0]       ctrl;
  logic              exit_req;
  logic [NUM_LOADS-1:0] relay_q;
  logic [CUR_W-1:0]  learned [NUM_LOADS];
  logic [CUR_W-1:0]  before_cur;
  logic [1:0]        learn_idx;
  logic              learning;
  logic [7:0]        settle_cnt;
  logic [CUR_W-1:0]  shown;
  lsd_service_e      svc;
  logic              managed;
  logic              aw_got;
  logic              w_got;
  logic [7:0]        aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;

  // split the display value into two decimal digits, saturating at 99
  function automatic logic [7:0] to_bcd(input logic [CUR_W-1:0] v);
    logic [7:0] s;
    logic [3:0] t;
    s = (v > METER_MAX) ? METER_MAX : v;
    t = 4'(s / 8'h0A);
    to_bcd = {t, 4'(s - 8'(t) * 8'h0A)};
  endfunction : to_bcd

  // ----------------------------------------------------------------------
  // tick divider and button
  // ----------------------------------------------------------------------
  // millisecond enable keeps all long timers narrow
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      div_cnt <= 18'h00000;
      ms_tick <= 1'b0;
    end
    else
    begin
      ms_tick <= (div_cnt == 18'(TICK_DIV - 1));
      div_cnt <= (div_cnt == 18'(TICK_DIV - 1)) ? 18'h00000 :
                 div_cnt + 18'h00001;
    end
  end

  lsd_button #(
    .DEBOUNCE (DEBOUNCE),
    .HOLD     (HOLD)
  ) u_button (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .ms_tick     (ms_tick),
    .btn_raw     (select_btn),
    .press_pulse (press_pulse),
    .hold_pulse  (hold_pulse)
  );

  // ----------------------------------------------------------------------
  // service detection
  // ----------------------------------------------------------------------
  assign powered = line_one_input | line_two_input;

  always_comb
  begin
    if (!powered)
      svc = LSD_SVC_OFF;
    else if (split_phase_detect && line_one_input && line_two_input)
      svc = LSD_SVC_FIFTY;
    else if (gen_run)
      svc = LSD_SVC_GEN;
    else
      svc = LSD_SVC_SHORE;
  end

  assign managed = (svc == LSD_SVC_SHORE) && ctrl[CTRL_SHED_EN];

  // ----------------------------------------------------------------------
  // limit mode
  // ----------------------------------------------------------------------
  // the selection is volatile: every new arrival of line power clears it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      power_q   <= 1'b0;
      limit_low <= 1'b0;
    end
    else
    begin
      power_q <= powered;
      if (powered && !power_q)
        limit_low <= 1'b0;
      else if (press_pulse && !review && svc == LSD_SVC_SHORE)
        limit_low <= !limit_low;
    end
  end

  // ----------------------------------------------------------------------
  // review mode
  // ----------------------------------------------------------------------
  assign exit_req = ctrl[CTRL_EXIT_REV];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      review  <= 1'b0;
      rev_idx <= 2'h0;
      rev_cnt <= 16'h0000;
    end
    else if (hold_pulse && !review)
    begin
      review  <= 1'b1;
      rev_idx <= 2'h0;
      rev_cnt <= 16'h0000;
    end
    else if (review)
    begin
      if (press_pulse || hold_pulse)
      begin
        rev_idx <= press_pulse ? rev_idx + 2'h1 : rev_idx;
        rev_cnt <= 16'h0000;
      end
      else if (exit_req || !powered)
        review <= 1'b0;
      else if (ms_tick)
      begin
        if (rev_cnt >= 16'(REVIEW_TO - 1))
          review <= 1'b0;
        else
          rev_cnt <= rev_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // relays and learning
  // ----------------------------------------------------------------------
  // relays are only energised while shore power is managed; contacts
  // rest closed in every other service so loads stay powered
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      relay_q <= '0;
    else
      relay_q <= managed ? shed_req : '0;
  end

  assign relay_out = relay_q;

  // one measurement at a time; a newer shed restarts the window
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      learning   <= 1'b0;
      learn_idx  <= 2'h0;
      before_cur <= '0;
      settle_cnt <= 8'h00;
      for (int i = 0; i < NUM_LOADS; i++)
        learned[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_LOADS; i++)
        if (managed && shed_req[i] && !relay_q[i])
        begin
          learning   <= 1'b1;
          learn_idx  <= 2'(i);
          before_cur <= total_current;
          settle_cnt <= 8'h00;
        end
      if (learning && !(managed && |(shed_req & ~relay_q)) && ms_tick)
      begin
        if (settle_cnt >= 8'(SETTLE - 1))
        begin
          learning <= 1'b0;
          learned[learn_idx] <= (before_cur > total_current) ?
                                before_cur - total_current : '0;
        end
        else
          settle_cnt <= settle_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // indicators, meter and configuration
  // ----------------------------------------------------------------------
  assign shown = review ? learned[rev_idx] : total_current;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      load_led    <= '0;
      led_gen     <= 1'b0;
      led_fifty   <= 1'b0;
      led_thirty  <= 1'b0;
      led_twenty  <= 1'b0;
      meter_tens  <= 4'h0;
      meter_ones  <= 4'h0;
      meter_blank <= 1'b1;
      limit_amps  <= LIMIT_HIGH_A;
      shed_order  <= 3'h7;
      stand_alone <= 1'b1;
    end
    else
    begin
      // follow the relay's next state so an led never lags its relay;
      // powered unmanaged services (fifty amp included) light every led
      for (int i = 0; i < NUM_LOADS; i++)
        load_led[i] <= review ? (rev_idx == 2'(i)) :
                       (powered && !(managed && shed_req[i]));
      led_fifty  <= (svc == LSD_SVC_FIFTY);
      led_gen    <= (svc == LSD_SVC_GEN);
      led_thirty <= (svc == LSD_SVC_SHORE) && !limit_low;
      led_twenty <= (svc == LSD_SVC_SHORE) && limit_low;
      meter_blank <= (svc == LSD_SVC_OFF) ||
                     (svc == LSD_SVC_FIFTY && !review);
      {meter_tens, meter_ones} <= to_bcd(shown);
      limit_amps <= limit_low ? LIMIT_LOW_A : LIMIT_HIGH_A;
      // position four is deliberately never read
      shed_order  <= cfg_sw[SW_ORDER_LSB +: 3];
      stand_alone <= cfg_sw[SW_STANDALONE];
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite write
  // ----------------------------------------------------------------------
  // address and data are held until the response is taken, so only one
  // write is ever in flight
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      ctrl          <= CTRL_RESET;
    end
    else
    begin
      ctrl[CTRL_EXIT_REV] <= 1'b0; // self clearing
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got        <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got        <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_got && w_got && !s_axi_bvalid)
      begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_q[7:2] == REG_CTRL[7:2])
        begin
          s_axi_bresp <= RESP_OKAY;
          if (w_strb_q[0])
          begin
            ctrl[CTRL_SHED_EN]  <= w_data_q[CTRL_SHED_EN];
            ctrl[CTRL_EXIT_REV] <= w_data_q[CTRL_EXIT_REV];
          end
        end
        else if (aw_addr_q[7:2] == REG_STATUS[7:2] ||
                 aw_addr_q[7:2] == REG_METER[7:2] ||
                 aw_addr_q[7:2] == REG_LEARNED[7:2])
          s_axi_bresp <= RESP_OKAY; // read-only, write ignored
        else
          s_axi_bresp <= RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      case (s_axi_araddr[7:2])
        REG_CTRL[7:2]:    s_axi_rdata <= {31'h0, ctrl[CTRL_SHED_EN]};
        REG_STATUS[7:2]:  s_axi_rdata <= {16'h0, 2'h0, stand_alone,
                                          shed_order, rev_idx, review,
                                          limit_low, 2'h0, svc, 2'h0};
        REG_METER[7:2]:   s_axi_rdata <= {16'h0, shown, total_current};
        REG_LEARNED[7:2]: s_axi_rdata <= {learned[3], learned[2],
                                          learned[1], learned[0]};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_hold_enter;
    hold_pulse && !review;
  endsequence

  sequence s_review_start;
    review && rev_idx == 2'h0;
  endsequence

  a_comp_relay: assert property (
    managed && shed_req[RELAY_COMP] |=> relay_out[RELAY_COMP])
    else $error("compressor relay not energised on shed");

  a_fan_relay: assert property (
    managed && shed_req[RELAY_FAN] |=> relay_out[RELAY_FAN])
    else $error("fan relay not energised on shed");

  a_idle_relays: assert property (
    !managed |=> relay_out == '0)
    else $error("relay energised while unmanaged");

  a_review_entry: assert property (
    s_hold_enter |=> s_review_start ##1 load_led == 4'h1)
    else $error("review entry did not select first load");

  a_power_restart: assert property (
    powered && !power_q |=> !limit_low ##1 !led_twenty)
    else $error("line power arrival did not select 30 A");

  a_toggle_limit: assert property (
    press_pulse && !review && svc == LSD_SVC_SHORE && !(powered && !power_q)
    |=> limit_low != $past(limit_low))
    else $error("press did not toggle limit");

  a_fifty_blank: assert property (
    svc == LSD_SVC_FIFTY && !review |=> meter_blank && led_fifty
    && load_led == 4'hF)
    else $error("fifty amp display wrong");

  a_twenty_led: assert property (
    led_twenty |-> $past(limit_low) && !led_thirty)
    else $error("twenty led without reduced mode");

  a_limit_value: assert property (
    limit_low |=> limit_amps == LIMIT_LOW_A)
    else $error("reduced limit not 20 A");

  a_config_sw: assert property (
    ##1 stand_alone == $past(cfg_sw[SW_STANDALONE]))
    else $error("stand alone does not follow switch five");

  a_live_meter: assert property (
    !review && total_current == 8'h1C |=> meter_tens == 4'h2
    && meter_ones == 4'h8)
    else $error("live meter digits wrong");

endmodule : lsd_ctrl

/* lsd_partner.sv */
`timescale 1ns/10ps
// far side: user at the select button and the supply sensing
module lsd_partner (
  input  wire logic clk,
  output logic      select_btn,
  output logic      line_one_input,
  output logic      line_two_input,
  output logic      split_phase_detect,
  output logic      gen_run
);
  // nothing pressed and no supply until the bench asks for it
  initial
  begin
    select_btn = 1'b0;
    {line_one_input, line_two_input, split_phase_detect, gen_run} = 4'h0;
  end
  // clean press of n clocks; bounce is left to the debounce logic
  task automatic push(input int n);
    select_btn <= 1'b1;
    repeat (n) @(posedge clk);
    select_btn <= 1'b0;
  endtask : push
  // supply code {line one, line two, split phase, generator run}
  task automatic supply(input logic [3:0] s);
    {line_one_input, line_two_input, split_phase_detect, gen_run} <= s;
  endtask : supply
endmodule : lsd_partner

/* load_service_display_ctrl_tb.sv */
`timescale 1ns/10ps
module load_service_display_ctrl_tb;
  import lsd_pkg::*;
  localparam int TK = 4; // clocks per tick, shortened for simulation
  logic        clk = 1'b0, sys_rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [7:0]  total_current = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, rnd = 32'h8197;
  logic [3:0]  s_axi_wstrb = 4'hF, shed_req = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        select_btn, line_one_input, line_two_input, gen_run;
  logic        split_phase_detect, meter_blank, stand_alone;
  logic        led_gen, led_fifty, led_thirty, led_twenty;
  logic [3:0]  relay_out, load_led, meter_tens, meter_ones;
  logic [5:0]  cfg_sw = SW_FACTORY, limit_amps;
  logic [2:0]  shed_order;
  int          failures = 0, n_checks = 0;
  wire logic [3:0] svc = {led_gen, led_fifty, led_thirty, led_twenty};
  wire logic [7:0] mtr = {meter_tens, meter_ones};

  lsd_ctrl #(.TICK_DIV(TK), .REVIEW_TO(20), .HOLD(10), .DEBOUNCE(2),
    .SETTLE(3)) u_lsd_ctrl (.*);
  lsd_partner u_lsd_partner (.*);

  // 250 MHz clock
  always #2 clk = ~clk;

  // hang guard: the sequence needs about 520 clocks
  initial
  begin
    #40000;
    failures++;
    end_sim();
  end

  // repeatable pseudo-random source
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // meter digits, saturating at 99
  function automatic logic [7:0] bcd(input logic [7:0] v);
    return (v > 8'h63) ? 8'h99 : {4'(v / 8'h0A), 4'(v % 8'h0A)};
  endfunction : bcd

  task automatic chk(input string nm, input logic [63:0] e, g);
    n_checks++;
    failures += int'(g !== e);
    if (g !== e)
      $display("BAD %s exp %h got %h", nm, e, g);
  endtask : chk

  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  // outputs are looked at on the falling edge, well clear of updates
  task automatic sm(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : sm
  task automatic sup(input logic [3:0] s);
    @(posedge clk);
    u_lsd_partner.supply(s);
    sm(3);
  endtask : sup
  // press of t ticks, then wait out debounce and output latency
  task automatic prs(input int t);
    @(posedge clk);
    u_lsd_partner.push(t * TK);
    sm(6 * TK);
  endtask : prs

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while ((s_axi_awvalid && !s_axi_awready) ||
           (s_axi_wvalid && !s_axi_wready));
    do @(posedge clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    {rd, rs} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rdr

  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    sm(2);
    chk("rst", {LIMIT_HIGH_A, 4'hF},
        {limit_amps, shed_order, stand_alone});
    sup(4'h8);
    chk("svc", 4'h2, svc);
    repeat (16)
    begin
      @(posedge clk);
      rnd = lfsr(rnd);
      total_current <= rnd[7:0];
      shed_req <= rnd[11:8];
      cfg_sw <= rnd[17:12];
      sm(3);
      chk("meter", bcd(rnd[7:0]), mtr);
      chk("relay", rnd[11:8], relay_out);
      chk("load", 4'(~rnd[11:8]), load_led);
      chk("cfg", {rnd[14:12], rnd[16]},
          {shed_order, stand_alone});
    end
    // shedding off by register, then an unmapped place both ways
    @(posedge clk);
    shed_req <= 4'hF;
    wr(REG_CTRL, 32'h0);
    rdr(REG_CTRL);
    chk("ctrl", {32'h0, 4'h0}, {rd, relay_out});
    rdr(8'h10);
    chk("rresp", {RESP_SLVERR, 32'h0}, {rs, rd});
    wr(8'h10, 32'h1);
    chk("bresp", RESP_SLVERR, rs);
    // second reset clears learned values; then shed load 0 with a drop
    @(posedge clk);
    {sys_rst, shed_req, cfg_sw, total_current} <=
      {1'b1, 4'h0, SW_FACTORY, 8'h1C};
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    shed_req <= 4'h1;
    repeat (2) @(posedge clk);
    total_current <= 8'h0F;
    repeat (5 * TK) @(posedge clk);
    shed_req <= 4'h0;
    // a one tick blip is shorter than the debounce window
    prs(1);
    chk("short", LIMIT_HIGH_A, limit_amps);
    prs(4);
    chk("low", {LIMIT_LOW_A, 4'h1}, {limit_amps, svc});
    prs(4);
    chk("high", {LIMIT_HIGH_A, 4'h2}, {limit_amps, svc});
    prs(14);
    chk("rev0", {LIMIT_HIGH_A, 4'h1, 8'h13},
        {limit_amps, load_led, mtr});
    prs(4);
    chk("rev1", {4'h2, 8'h00}, {load_led, mtr});
    sm(12 * TK);
    chk("stay", 4'h2, load_led);
    sm(10 * TK);
    chk("live", {4'hF, 8'h15}, {load_led, mtr});
    prs(4);
    sup(4'h0);
    chk("off", {LIMIT_LOW_A, 1'b1}, {limit_amps, meter_blank});
    sup(4'h8);
    chk("power", LIMIT_HIGH_A, limit_amps);
    @(posedge clk);
    shed_req <= 4'hF;
    sup(4'h9);
    chk("gen", {4'h8, 4'hF}, {svc, load_led});
    sup(4'hE);
    chk("fifty", {4'h4, 4'h0, 4'hF, 1'b1},
        {svc, relay_out, load_led, meter_blank});
    end_sim();
  end
endmodule : load_service_display_ctrl_tb
